// ### rtl/ecb_pkg.sv
// Package: constants and carriers for the event counter bank
package ecb_pkg;

  localparam logic [31:0] CTR_BASE = 32'h0000_00c1;
  localparam logic [31:0] SEL_BASE = 32'h0000_0186;
  localparam logic [31:0] CAP_ADDR = 32'h0000_0100;
  localparam logic [31:0] CAP_UNAVAIL_ADDR = 32'h0000_0101;

  localparam int SEL_EVT_LO = 0;
  localparam int SEL_QUAL_LO = 8;
  localparam int SEL_USR_BIT = 16;
  localparam int SEL_KRN_BIT = 17;
  localparam int SEL_EDGE_BIT = 18;
  localparam int SEL_PIN_BIT = 19;
  localparam int SEL_RSV_BIT = 21;
  localparam int SEL_INT_BIT = 20;
  localparam int SEL_EN_BIT = 22;
  localparam int SEL_INV_BIT = 23;
  localparam int SEL_THR_LO = 24;
  localparam int SIGN_BIT = 31;

  localparam int CAP_VER_LO = 0;
  localparam int CAP_NCTR_LO = 8;
  localparam int CAP_WIDTH_LO = 16;
  localparam int CAP_NEVT_LO = 24;

  localparam logic [63:0] SEL_RESET = 64'h0;
  localparam logic [63:0] CTR_RESET = 64'h0;
  localparam logic [63:0] SEL_WMASK = 64'h0000_0000_ffdf_ffff;

  typedef struct packed {
    logic [7:0] thresh;
    logic compare_invert_flag;
    logic en;
    logic rsv;
    logic irq;
    logic pin;
    logic edge_det;
    logic krn;
    logic user_level_flag;
    logic [7:0] qual;
    logic [7:0] evt;
  } ecb_sel_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [63:0] wdata;
  } ecb_req_s;

endpackage : ecb_pkg

// ### rtl/ecb_ctr_mem.sv
// Counter storage for one logical processor, registered read port
`timescale 1ns/1ps
module ecb_ctr_mem #(
  parameter int N = 4,
  parameter int W = 48
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [N-1:0] ld,
  input wire logic [N*W-1:0] ld_val,
  input wire logic [N-1:0] inc,
  input wire logic [N*W-1:0] inc_val,
  input wire logic [$clog2(N)-1:0] raddr,
  output logic [W-1:0] rdata,
  output logic [N*W-1:0] cur,
  output logic [N-1:0] wrap
);
  logic [W-1:0] mem_q [N];
  logic [W:0] sum [N];

  for (genvar i = 0; i < N; i++) begin : g_c
    assign sum[i] = {1'b0, mem_q[i]} + {1'b0, inc_val[i*W +: W]};
    assign cur[i*W +: W] = mem_q[i];
    // Wrap past full scale is the overflow event
    assign wrap[i] = inc[i] & ~ld[i] & sum[i][W];
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        mem_q[i] <= '0;
      end else if (ld[i]) begin
        mem_q[i] <= ld_val[i*W +: W];
      end else if (inc[i]) begin
        mem_q[i] <= sum[i][W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule : ecb_ctr_mem

// ### rtl/ecb_top.sv
// Event counter bank for one logical processor
`timescale 1ns/1ps
module ecb_top #(
  parameter int NCTR = 4,
  parameter int CW = 48,
  parameter int NSRC = 8,
  parameter int QW = 4,
  parameter logic [7:0] VERSION = 8'h01,
  parameter logic [7:0] NUM_EVENTS = 8'h07,
  parameter logic [31:0] UNAVAIL_MASK = 32'h0000_0000,
  parameter bit LEGACY_PIN = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ecb_pkg::ecb_req_s req,
  input wire logic [1:0] priv_level,
  input wire logic [NSRC*256*QW-1:0] evt_counts,
  output logic [63:0] rd_data,
  output logic rd_valid,
  output logic [NCTR-1:0] monitor_pin,
  output logic [NCTR-1:0] local_irq
);
  localparam int AW = $clog2(NCTR);

  // Private selector set; one instance per logical processor
  ecb_pkg::ecb_sel_s sel_q [NCTR];
  logic [NCTR-1:0] cnt_ld;
  logic [NCTR*CW-1:0] cnt_ld_val;
  logic [NCTR-1:0] cnt_inc;
  logic [NCTR*CW-1:0] cnt_inc_val;
  logic [NCTR*CW-1:0] cnt_cur;
  logic [NCTR-1:0] cnt_wrap;
  logic [CW-1:0] ctr_rdata;
  logic [NCTR-1:0] cond_prev_q;
  logic [NCTR-1:0] pin_q;
  logic [NCTR-1:0] irq_q;
  logic [1:0] rsel_q;
  logic [63:0] sel_rd_q;
  logic [63:0] cap_rd_q;
  logic rd_valid_q;

  function automatic logic in_block(input logic [31:0] a, input logic [31:0] base);
    in_block = (a >= base) && (a < base + 32'(NCTR));
  endfunction : in_block

  function automatic logic [AW-1:0] idx_of(input logic [31:0] a, input logic [31:0] base);
    logic [31:0] d;
    d = a - base;
    idx_of = d[AW-1:0];
  endfunction : idx_of

  wire ctr_hit = in_block(req.addr, ecb_pkg::CTR_BASE);
  wire sel_hit = in_block(req.addr, ecb_pkg::SEL_BASE);
  wire cap_hit = (req.addr == ecb_pkg::CAP_ADDR);
  wire cap_un_hit = (req.addr == ecb_pkg::CAP_UNAVAIL_ADDR);
  wire [AW-1:0] ctr_idx = idx_of(req.addr, ecb_pkg::CTR_BASE);
  wire [AW-1:0] sel_idx = idx_of(req.addr, ecb_pkg::SEL_BASE);

  // Capability word
  wire [7:0] cap_nctr = 8'(NCTR);
  wire [7:0] cap_width = 8'(CW);
  wire [63:0] cap_word = {32'h0, NUM_EVENTS, cap_width, cap_nctr, VERSION};

  // Low word kept, bit 31 copied into every higher bit
  function automatic logic [63:0] sext_low(
    input logic [63:0] d
  );
    logic [31:0] lo;
    lo = d[31:0];
    sext_low = {{32{lo[ecb_pkg::SIGN_BIT]}}, lo};
  endfunction : sext_low

  wire [63:0] wr_sext = sext_low(req.wdata);

  // Reserved bit 21 and, on newer parts, bit 19 are dropped on write
  wire [63:0] sel_wmask = LEGACY_PIN ? ecb_pkg::SEL_WMASK
                        : (ecb_pkg::SEL_WMASK & ~(64'h1 << ecb_pkg::SEL_PIN_BIT));
  wire [63:0] sel_wval = req.wdata & sel_wmask;

  wire is_user = (priv_level != 2'h0);

  // Privilege filter: user bit covers levels 1 to 3, kernel bit level 0
  function automatic logic priv_match(
    input ecb_pkg::ecb_sel_s s,
    input logic user_mode
  );
    logic hit_user;
    logic hit_krn;
    hit_user = s.user_level_flag & user_mode;
    hit_krn = s.krn & ~user_mode;
    priv_match = hit_user | hit_krn;
  endfunction : priv_match

  // Threshold compare; invert turns ge into lt
  function automatic logic thr_check(
    input ecb_pkg::ecb_sel_s s,
    input logic [QW-1:0] cnt
  );
    logic ge;
    ge = (8'(cnt) >= s.thresh);
    thr_check = s.compare_invert_flag ? ~ge : ge;
  endfunction : thr_check

  // Condition seen by the edge detector
  function automatic logic cond_of(
    input ecb_pkg::ecb_sel_s s,
    input logic [QW-1:0] cnt
  );
    if (s.thresh != 8'h0) begin
      cond_of = thr_check(s, cnt);
    end else begin
      cond_of = (cnt != '0);
    end
  endfunction : cond_of

  // Per-cycle increment: edge mode, threshold mode or raw count
  function automatic logic [QW-1:0] step_of(
    input ecb_pkg::ecb_sel_s s,
    input logic [QW-1:0] cnt,
    input logic rise
  );
    logic [QW-1:0] step;
    step = cnt;
    if (s.edge_det) begin
      step = QW'(rise);
    end else if (s.thresh != 8'h0) begin
      step = QW'(thr_check(s, cnt));
    end
    step_of = step;
  endfunction : step_of

  // Event slot; only eight sources fit the three slot bits
  function automatic logic [11:0] slot_of(
    input ecb_pkg::ecb_sel_s s
  );
    logic [7:0] src;
    src = s.evt % 8'(NSRC);
    slot_of = {1'b0, src[2:0], s.qual};
  endfunction : slot_of

  for (genvar i = 0; i < NCTR; i++) begin : g_ch
    wire [QW-1:0] raw_cnt;
    wire [QW-1:0] sel_cnt;
    wire cond;
    wire edge_ok;
    wire [QW-1:0] amount;
    wire [11:0] src_idx;
    wire sel_wr;
    wire pin_fire;
    wire irq_fire;

    assign src_idx = slot_of(sel_q[i]);
    assign raw_cnt = evt_counts[32'(src_idx) * QW +: QW];
    assign sel_cnt = priv_match(sel_q[i], is_user) ? raw_cnt : '0;
    // Threshold result or any event, by the threshold field
    assign cond = cond_of(sel_q[i], sel_cnt);
    assign edge_ok = cond & ~cond_prev_q[i];
    assign amount = step_of(sel_q[i], sel_cnt, edge_ok);
    assign cnt_inc[i] = sel_q[i].en && (amount != '0);
    assign cnt_inc_val[i*CW +: CW] = CW'(amount);
    assign cnt_ld[i] = req.wr && ctr_hit && (ctr_idx == AW'(i));
    // Only meaningful if enable is cleared first; write wins anyway
    assign cnt_ld_val[i*CW +: CW] = CW'(wr_sext);
    assign sel_wr = req.wr && sel_hit && (sel_idx == AW'(i));
    // Each cycle the counter counts in legacy pin mode, else on wrap
    assign pin_fire = (LEGACY_PIN && sel_q[i].pin) ? cnt_inc[i] : cnt_wrap[i];
    assign irq_fire = cnt_wrap[i] & sel_q[i].irq;

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        sel_q[i] <= ecb_pkg::SEL_RESET[31:0];
      end else if (sel_wr) begin
        sel_q[i] <= sel_wval[31:0];
      end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        cond_prev_q[i] <= 1'b0;
      end else begin
        cond_prev_q[i] <= cond & sel_q[i].en;
      end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pin_q[i] <= 1'b0;
      end else begin
        pin_q[i] <= pin_fire;
      end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        irq_q[i] <= 1'b0;
      end else begin
        irq_q[i] <= irq_fire;
      end
    end
  end

  ecb_ctr_mem #(
    .N(NCTR),
    .W(CW)
  ) u_mem (
    .ref_clk(ref_clk),
    .rst(rst),
    .ld(cnt_ld),
    .ld_val(cnt_ld_val),
    .inc(cnt_inc),
    .inc_val(cnt_inc_val),
    .raddr(ctr_idx),
    .rdata(ctr_rdata),
    .cur(cnt_cur),
    .wrap(cnt_wrap)
  );

  // Read source code: 1 counter, 2 selector, 3 capability, 0 unmapped
  function automatic logic [1:0] rsel_of(
    input logic c,
    input logic s,
    input logic k
  );
    logic [1:0] code;
    code = 2'h0;
    if (c) begin
      code = 2'h1;
    end else if (s) begin
      code = 2'h2;
    end else if (k) begin
      code = 2'h3;
    end
    rsel_of = code;
  endfunction : rsel_of

  // Read path: two cycle latency, unmapped reads return zero
  wire [1:0] rsel_d = rsel_of(ctr_hit, sel_hit, cap_hit | cap_un_hit);
  wire [63:0] cap_d = cap_hit ? cap_word : {32'h0, UNAVAIL_MASK};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsel_q <= 2'h0;
    end else begin
      rsel_q <= req.rd ? rsel_d : 2'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_rd_q <= 64'h0;
    end else begin
      sel_rd_q <= {32'h0, sel_q[sel_idx]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cap_rd_q <= 64'h0;
    end else begin
      cap_rd_q <= cap_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req.rd;
    end
  end

  // Counter reads return exactly CW valid bits
  function automatic logic [63:0] pick_rd(
    input logic [1:0] code,
    input logic [CW-1:0] ctr,
    input logic [63:0] sel,
    input logic [63:0] cap
  );
    case (code)
      2'h1: pick_rd = 64'(ctr);
      2'h2: pick_rd = sel;
      2'h3: pick_rd = cap;
      default: pick_rd = 64'h0;
    endcase
  endfunction : pick_rd

  wire [63:0] rd_mux = pick_rd(rsel_q, ctr_rdata, sel_rd_q, cap_rd_q);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 64'h0;
    end else begin
      rd_data <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_valid_q;
    end
  end

  // Extra stage keeps every output straight from a flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      monitor_pin <= '0;
    end else begin
      monitor_pin <= pin_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      local_irq <= '0;
    end else begin
      local_irq <= irq_q;
    end
  end
endmodule : ecb_top

// ### sim/ecb_top_chk.sv
// Port checker for the event counter bank
`timescale 1ns/1ps
module ecb_top_chk #(
  parameter int NCTR = 4,
  parameter int CW = 48,
  parameter int NSRC = 8,
  parameter int QW = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ecb_pkg::ecb_req_s req,
  input wire logic [1:0] priv_level,
  input wire logic [NSRC*256*QW-1:0] evt_counts,
  input wire logic [63:0] rd_data,
  input wire logic rd_valid,
  input wire logic [NCTR-1:0] monitor_pin,
  input wire logic [NCTR-1:0] local_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire cap_rd = req.rd && req.addr == ecb_pkg::CAP_ADDR;
  wire ctr_rd = req.rd && req.addr >= ecb_pkg::CTR_BASE && req.addr < ecb_pkg::CTR_BASE + NCTR;
  wire sel_rd = req.rd && req.addr >= ecb_pkg::SEL_BASE && req.addr < ecb_pkg::SEL_BASE + NCTR;
  wire gap_rd = req.rd && req.addr == 32'h0000_0050;
  sequence s_answer;
    ##2 rd_valid;
  endsequence
  rd_lat_a: assert property (req.rd |-> s_answer) else $error("no read answer");
  rd_only_a: assert property (rd_valid |-> $past(req.rd, 2)) else $error("stray answer");
  cap_count_a: assert property (cap_rd |-> ##2 rd_data[15:8] == 8'(NCTR))
    else $error("counter count");
  cap_width_a: assert property (cap_rd |-> ##2 rd_data[23:16] == 8'(CW))
    else $error("counter width");
  cap_ver_a: assert property (cap_rd |-> ##2 rd_data[7:0] != 8'h00) else $error("version");
  ctr_bits_a: assert property (ctr_rd |-> ##2 rd_data[63:CW] == '0) else $error("ctr bits");
  sel_rsv_a: assert property (sel_rd |-> ##2 !rd_data[21] && rd_data[63:32] == 32'h0)
    else $error("reserved bit");
  gap_zero_a: assert property (gap_rd |-> ##2 rd_data == 64'h0) else $error("unmapped");
  irq_once_a: assert property (local_irq[0] |=> !local_irq[0]) else $error("irq width");
endmodule : ecb_top_chk
bind ecb_top ecb_top_chk #(.NCTR(NCTR), .CW(CW), .NSRC(NSRC), .QW(QW)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .req(req), .priv_level(priv_level), .evt_counts(evt_counts),
  .rd_data(rd_data), .rd_valid(rd_valid), .monitor_pin(monitor_pin), .local_irq(local_irq));

// ### sim/tb_top.sv
// Self-checking bench for the event counter bank
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  ecb_pkg::ecb_req_s req = '0;
  logic [1:0] priv_level = 2'h0;
  logic [8191:0] evt_counts = '0;
  logic [63:0] rd_data;
  logic rd_valid;
  logic [3:0] monitor_pin;
  logic [3:0] local_irq;
  int bad_count = 0;
  int samples_checked = 0;
  int pin_n = 0;
  int irq_n = 0;
  ecb_top #(.VERSION(8'h01), .NUM_EVENTS(8'h07), .UNAVAIL_MASK(32'h0000_0005)) DUT (
    .ref_clk(ref_clk), .rst(rst), .req(req), .priv_level(priv_level), .evt_counts(evt_counts),
    .rd_data(rd_data), .rd_valid(rd_valid), .monitor_pin(monitor_pin), .local_irq(local_irq));
  always #5 ref_clk = ~ref_clk;
  // Pulse tallies, so back-to-back pulses are not lost
  always @(posedge ref_clk) begin
    pin_n <= pin_n + int'(monitor_pin[0]);
    irq_n <= irq_n + int'(local_irq[0]);
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] e);
    samples_checked++;
    if (seen !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [63:0] e);
    @(posedge ref_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("rd_valid", {63'h0, rd_valid}, 64'h1);
    chk("rd_data", rd_data, e);
  endtask : rd
  // Source 3, qualifier 5 feeds counter 0 for n cycles
  task automatic run(input logic [31:0] s, input logic [1:0] p, input logic [3:0] v,
                     input int n, input logic [63:0] init, input logic [63:0] e);
    wr(ecb_pkg::SEL_BASE, 64'h0);
    wr(ecb_pkg::CTR_BASE, init);
    wr(ecb_pkg::SEL_BASE, {32'h0, s});
    priv_level <= p;
    @(posedge ref_clk);
    evt_counts[(3*256+5)*4 +: 4] <= v;
    repeat (n) @(posedge ref_clk);
    evt_counts[(3*256+5)*4 +: 4] <= 4'h0;
    repeat (4) @(posedge ref_clk);
    wr(ecb_pkg::SEL_BASE, 64'h0);
    rd(ecb_pkg::CTR_BASE, e);
  endtask : run
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    int p0;
    int i0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ecb_pkg::CAP_ADDR, 64'h0730_0401);
    rd(ecb_pkg::CAP_UNAVAIL_ADDR, 64'h5);
    rd(32'h0000_0050, 64'h0);
    rd(ecb_pkg::SEL_BASE + 4, 64'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ecb_pkg::CTR_BASE + i, 64'h1234_0000_8000_0000 + i);
      wr(ecb_pkg::SEL_BASE + i, 64'h0000_0303 + i);
    end
    for (int i = 0; i < 4; i++) begin
      rd(ecb_pkg::CTR_BASE + i, 64'hffff_8000_0000 + i);
      rd(ecb_pkg::SEL_BASE + i, 64'h0000_0303 + i);
    end
    wr(ecb_pkg::CTR_BASE + 1, 64'haaaa_aaaa_7fff_ffff);
    rd(ecb_pkg::CTR_BASE + 1, 64'h7fff_ffff);
    wr(ecb_pkg::SEL_BASE + 1, '1);
    rd(ecb_pkg::SEL_BASE + 1, 64'hffdf_ffff);
    run(32'h0041_0503, 2'h1, 4'h3, 4, 64'h0, 64'hc);
    run(32'h0041_0503, 2'h0, 4'h3, 4, 64'h0, 64'h0);
    run(32'h0042_0503, 2'h0, 4'h3, 4, 64'h0, 64'hc);
    run(32'h0241_0503, 2'h1, 4'h3, 4, 64'h0, 64'h4);
    // Inverted compare also passes on the seven idle enabled cycles
    run(32'h02c1_0503, 2'h1, 4'h3, 4, 64'h0, 64'h7);
    run(32'h02c1_0503, 2'h1, 4'h1, 4, 64'h0, 64'hb);
    run(32'h0045_0503, 2'h1, 4'h1, 4, 64'h0, 64'h1);
    run(32'h0001_0503, 2'h1, 4'h3, 4, 64'h0, 64'h0);
    run(32'h0041_0603, 2'h1, 4'h3, 4, 64'h0, 64'h0);
    p0 = pin_n;
    i0 = irq_n;
    run(32'h0051_0503, 2'h1, 4'h1, 1, 64'hffff_ffff, 64'h0);
    chk("irq", 64'(irq_n - i0), 64'h1);
    chk("pin", 64'(pin_n - p0), 64'h1);
    p0 = pin_n;
    run(32'h0049_0503, 2'h1, 4'h1, 3, 64'h0, 64'h3);
    chk("pin", 64'(pin_n - p0), 64'h3);
    wrap_up();
  end
endmodule : tb_top
